// ===== hdl/sfsrc_pkg.sv
// constants, types and carriers shared by the serial flash command front end
package sfsrc_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE_ENABLE        = 8'h06; // write_enable_command
	localparam logic [7:0] OPC_WRITE_DISABLE       = 8'h04; // clears the latch
	localparam logic [7:0] OPC_READ_STATUS_LOW     = 8'h05; // status bits 7..0
	localparam logic [7:0] OPC_READ_STATUS_HIGH    = 8'h35; // status bits 15..8
	localparam logic [7:0] OPC_BUSY_MONITOR        = 8'h25; // busy_monitor_command
	localparam logic [7:0] OPC_STATUS_WRITE        = 8'h01; // status_write_command
	localparam logic [7:0] OPC_READ                = 8'h03; // basic read
	localparam logic [7:0] OPC_FAST_READ           = 8'h0b; // read with dummy byte
	localparam logic [7:0] OPC_DUAL_OUTPUT_READ    = 8'h3b; // dual_output_read_command
	localparam logic [7:0] OPC_DUAL_LINE_ADDR_READ = 8'hbb; // dual_line_address_read_command
	localparam logic [7:0] OPC_ERASE_SUSPEND       = 8'h75; // sets erase flag
	localparam logic [7:0] OPC_PROGRAM_SUSPEND     = 8'hb0; // sets program flag
	localparam logic [7:0] OPC_RESUME_A            = 8'h7a; // clears both flags
	localparam logic [7:0] OPC_RESUME_B            = 8'h30; // clears both flags

	// ----------------------------------------------------------------
	// status word layout
	// ----------------------------------------------------------------
	localparam int          BIT_BUSY            = 0;  // busy_flag
	localparam int          BIT_WEL             = 1;  // write_enable_latch
	localparam int          BIT_LOCK_LOWER      = 7;  // status_lock_lower
	localparam int          BIT_LOCK_UPPER      = 8;  // status_lock_upper
	localparam int          BIT_PROG_SUSPENDED  = 10; // program_suspended_flag
	localparam int          BIT_ERASE_SUSPENDED = 15; // erase_suspended_flag
	localparam int          LOCK_BITS_LSB       = 11; // one-time lock field low end
	localparam int          LOCK_BITS_MSB       = 13; // one-time lock field high end
	localparam logic [15:0] STATUS_RESET        = 16'h0000; // everything clear
	localparam logic [15:0] MASK_BYTE_WRITE     = 16'h00fc; // bits 7..2
	localparam logic [15:0] MASK_WORD_WRITE     = 16'h7bfc; // 14..11, 9, 8, 7..2

	// ----------------------------------------------------------------
	// framing and timing
	// ----------------------------------------------------------------
	localparam logic [5:0]  ADDR_BITS        = 6'h18; // 3-byte address
	localparam logic [5:0]  DUMMY_CLOCKS     = 6'h08; // dummy clocks of the fast reads
	localparam logic [5:0]  OPCODE_LAST_BIT  = 6'h07; // eighth opcode bit
	localparam logic [5:0]  WRITE_SHORT_BITS = 6'h08; // one data byte
	localparam logic [5:0]  WRITE_LONG_BITS  = 6'h10; // two data bytes
	localparam logic [4:0]  SYNC_RESET       = 5'h12; // chip select and protect idle high
	localparam int          CLK_MHZ          = 200;
	localparam int          STATUS_WRITE_CYCLE_TIME_NS = 5000; // status_write_cycle_time
	localparam int          STATUS_WRITE_CYCLE_CLKS =
		(STATUS_WRITE_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OPCODE      = 3'b000,
		ST_ADDRESS     = 3'b001,
		ST_DUMMY       = 3'b010,
		ST_DATA        = 3'b011,
		ST_STATUS_IN   = 3'b100,
		ST_MONITOR_ARM = 3'b101,
		ST_MONITOR     = 3'b110,
		ST_IGNORE      = 3'b111
	} sfsrc_state_t;

	typedef enum logic [1:0] {
		SRC_ARRAY       = 2'b00,
		SRC_STATUS_LOW  = 2'b01,
		SRC_STATUS_HIGH = 2'b10
	} sfsrc_src_t;

	typedef struct packed {
		logic io1_o;  // serial out / upper line
		logic io1_oe; // high while driving io_line_1
		logic io0_o;  // lower line in dual modes
		logic io0_oe; // high while driving io_line_0
	} sfsrc_io_t;

endpackage

// ===== hdl/sfsrc_flash_front.sv
// serial flash command front end: status word, busy monitor, status write, reads
`timescale 1ns/1ps
`default_nettype none

module sfsrc_flash_front #(
	parameter int unsigned ADDR_W          = 19,  // array address width, 4 Mbit
	parameter int unsigned STATUS_WRITE_COMMAND_CYCLE_CLKS = sfsrc_pkg::STATUS_WRITE_CYCLE_CLKS
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                io0_i,
	input  wire logic                io1_i,
	input  wire logic                wp_n,
	input  wire logic                array_busy,
	input  wire logic                mem_load_en,
	input  wire logic [ADDR_W-1:0]   mem_load_addr,
	input  wire logic [7:0]          mem_load_data,
	output var  sfsrc_pkg::sfsrc_io_t io_out,
	output logic [15:0]              status_word
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (ADDR_W < 1 || ADDR_W > 24)
		begin : g_bad_addr
			$error("address width must lie between 1 and 24");
		end
		if (STATUS_WRITE_COMMAND_CYCLE_CLKS < 1 || STATUS_WRITE_COMMAND_CYCLE_CLKS > 65535)
		begin : g_bad_cycle
			$error("status write cycle count out of range");
		end
	endgenerate

	localparam int unsigned WIP_W = $clog2(STATUS_WRITE_COMMAND_CYCLE_CLKS + 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [4:0]              sync1_r;       // first stage, read only by second
	logic [4:0]              sync2_r;       // settled pin levels
	logic [4:0]              pin_raw;       // raw pin levels in stage order
	logic                    sck_q_r;       // previous clock level
	logic                    cs_q_r;        // previous select level
	logic                    sck_s;         // synchronised serial clock
	logic                    cs_s;          // synchronised chip select, high = idle
	logic                    io0_s;         // synchronised lower line
	logic                    io1_s;         // synchronised upper line
	logic                    wp_s;          // synchronised protect pin
	logic                    sck_rise;      // sample point inside a frame
	logic                    sck_fall;      // launch point inside a frame
	logic                    cs_rise;       // end of frame
	sfsrc_pkg::sfsrc_state_t state_r;       // command phase
	sfsrc_pkg::sfsrc_src_t   src_r;         // where output bytes come from
	logic [5:0]              cnt_r;         // bits or clocks in current phase
	logic [5:0]              cnt_nxt;       // count after this rising edge
	logic                    dual_in_r;     // address and dummy on two lines
	logic                    dual_out_r;    // data on two lines
	logic                    dummy_en_r;    // a dummy phase follows the address
	logic [23:0]             in_sr_r;       // incoming bits, newest in bit 0
	logic [23:0]             in_sr_nxt;     // shift result of this edge
	logic [7:0]              out_sr_r;      // rest of the byte being sent
	logic [2:0]              out_cnt_r;     // bits of the byte already sent
	logic [ADDR_W-1:0]       rd_addr_r;     // next array byte to send
	logic [7:0]              cur_byte;      // byte feeding the next launch
	sfsrc_pkg::sfsrc_io_t    pins_r;        // pin drive flops
	logic [15:0]             stat_r;        // stored status bits, bit 0 unused
	logic [15:0]             stat_written;  // status after a valid write
	logic [15:0]             stat_word;     // live status view
	logic [15:0]             status_word_r; // registered status view
	logic [WIP_W-1:0]        wip_cnt_r;     // cycles left of the write cycle
	logic                    busy_now;      // busy_flag value
	logic                    wip_done;      // last cycle of the write cycle
	logic                    opc_done;      // eighth opcode bit sampled now
	logic                    addr_load;     // last address bit sampled now
	logic                    write_locked;  // status writes are blocked
	logic                    status_write_command_go;       // start a status write cycle
	logic [7:0]              mem [0:(1 << ADDR_W) - 1]; // array contents

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// gathered first, since a concatenation cannot be indexed directly
	assign pin_raw = {wp_n, io1_i, io0_i, cs_n, sclk};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			// two flops per pin; nothing but stage two reads stage one
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					sync1_r[gi] <= sfsrc_pkg::SYNC_RESET[gi];
					sync2_r[gi] <= sfsrc_pkg::SYNC_RESET[gi];
				end
				else
				begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	assign sck_s = sync2_r[0];
	assign cs_s  = sync2_r[1];
	assign io0_s = sync2_r[2];
	assign io1_s = sync2_r[3];
	assign wp_s  = sync2_r[4];

	// ----------------------------------------------------------------
	// edge detection on the settled levels
	// ----------------------------------------------------------------
	// edge history for the link clock and the frame
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sck_q_r <= 1'b0;
			cs_q_r  <= 1'b1;
		end
		else
		begin
			sck_q_r <= sck_s;
			cs_q_r  <= cs_s;
		end
	end

	// rising edges sample, falling edges launch
	assign sck_rise = sck_s & ~sck_q_r & ~cs_s;
	assign sck_fall = ~sck_s & sck_q_r & ~cs_s;
	assign cs_rise  = cs_s & ~cs_q_r;

	// ----------------------------------------------------------------
	// input shifting
	// ----------------------------------------------------------------
	// two-line phases take the upper line as the earlier bit
	always_comb
	begin
		if (dual_in_r)
		begin
			in_sr_nxt = {in_sr_r[21:0], io1_s, io0_s};
			cnt_nxt   = cnt_r + 6'h02;
		end
		else
		begin
			in_sr_nxt = {in_sr_r[22:0], io0_s};
			cnt_nxt   = cnt_r + 6'h01;
		end
	end

	// shift register; frozen while monitoring so the input line has no say
	always_ff @(posedge clk)
	begin
		if (sys_rst || cs_s)
		begin
			in_sr_r <= 24'h000000;
		end
		else if (sck_rise && state_r != sfsrc_pkg::ST_MONITOR
			&& state_r != sfsrc_pkg::ST_MONITOR_ARM)
		begin
			in_sr_r <= in_sr_nxt;
		end
	end

	assign opc_done  = sck_rise && state_r == sfsrc_pkg::ST_OPCODE
		&& cnt_r == sfsrc_pkg::OPCODE_LAST_BIT;
	assign addr_load = sck_rise && state_r == sfsrc_pkg::ST_ADDRESS
		&& cnt_nxt == sfsrc_pkg::ADDR_BITS;

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	// every frame restarts at the opcode; a select rise aborts any phase
	always_ff @(posedge clk)
	begin
		if (sys_rst || cs_s)
		begin
			state_r    <= sfsrc_pkg::ST_OPCODE;
			cnt_r      <= 6'h00;
			dual_in_r  <= 1'b0;
			dual_out_r <= 1'b0;
			dummy_en_r <= 1'b0;
			src_r      <= sfsrc_pkg::SRC_ARRAY;
		end
		else if (sck_rise)
		begin
			case (state_r)
				sfsrc_pkg::ST_OPCODE:
				begin
					cnt_r <= cnt_nxt;
					if (opc_done)
					begin
						cnt_r <= 6'h00;
						// unknown and side-effect-only opcodes idle to the frame end
						state_r <= sfsrc_pkg::ST_IGNORE;
						case (in_sr_nxt[7:0])
							sfsrc_pkg::OPC_READ:
							begin
								state_r <= sfsrc_pkg::ST_ADDRESS;
							end
							sfsrc_pkg::OPC_FAST_READ:
							begin
								if (!busy_now)
								begin
									state_r    <= sfsrc_pkg::ST_ADDRESS;
									dummy_en_r <= 1'b1;
								end
							end
							sfsrc_pkg::OPC_DUAL_OUTPUT_READ:
							begin
								if (!busy_now)
								begin
									state_r    <= sfsrc_pkg::ST_ADDRESS;
									dummy_en_r <= 1'b1;
									dual_out_r <= 1'b1;
								end
							end
							sfsrc_pkg::OPC_DUAL_LINE_ADDR_READ:
							begin
								if (!busy_now)
								begin
									state_r    <= sfsrc_pkg::ST_ADDRESS;
									dummy_en_r <= 1'b1;
									dual_in_r  <= 1'b1;
									dual_out_r <= 1'b1;
								end
							end
							sfsrc_pkg::OPC_READ_STATUS_LOW:
							begin
								state_r <= sfsrc_pkg::ST_DATA;
								src_r   <= sfsrc_pkg::SRC_STATUS_LOW;
							end
							sfsrc_pkg::OPC_READ_STATUS_HIGH:
							begin
								state_r <= sfsrc_pkg::ST_DATA;
								src_r   <= sfsrc_pkg::SRC_STATUS_HIGH;
							end
							sfsrc_pkg::OPC_BUSY_MONITOR:
							begin
								state_r <= sfsrc_pkg::ST_MONITOR_ARM;
							end
							sfsrc_pkg::OPC_STATUS_WRITE:
							begin
								state_r <= sfsrc_pkg::ST_STATUS_IN;
							end
							default:
							begin
								state_r <= sfsrc_pkg::ST_IGNORE;
							end
						endcase
					end
				end
				sfsrc_pkg::ST_ADDRESS:
				begin
					cnt_r <= cnt_nxt;
					if (cnt_nxt == sfsrc_pkg::ADDR_BITS)
					begin
						cnt_r   <= 6'h00;
						state_r <= dummy_en_r ? sfsrc_pkg::ST_DUMMY : sfsrc_pkg::ST_DATA;
					end
				end
				sfsrc_pkg::ST_DUMMY:
				begin
					// counted in clocks, whatever the lane count
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == sfsrc_pkg::DUMMY_CLOCKS - 6'h01)
					begin
						cnt_r   <= 6'h00;
						state_r <= sfsrc_pkg::ST_DATA;
					end
				end
				sfsrc_pkg::ST_STATUS_IN:
				begin
					// saturate so an overlong write never aliases to 8 or 16
					if (cnt_r != 6'h3f)
					begin
						cnt_r <= cnt_r + 6'h01;
					end
				end
				sfsrc_pkg::ST_MONITOR_ARM:
				begin
					state_r <= sfsrc_pkg::ST_MONITOR;
				end
				default:
				begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output path and array address
	// ----------------------------------------------------------------
	// array is written only through the same-clock load port
	always_ff @(posedge clk)
	begin
		if (mem_load_en)
		begin
			mem[mem_load_addr] <= mem_load_data;
		end
	end

	// a new byte is fetched when the previous one is fully sent
	always_comb
	begin
		cur_byte = out_sr_r;
		if (out_cnt_r == 3'h0)
		begin
			case (src_r)
				sfsrc_pkg::SRC_STATUS_LOW:  cur_byte = stat_word[7:0];
				sfsrc_pkg::SRC_STATUS_HIGH: cur_byte = stat_word[15:8];
				default:                    cur_byte = mem[rd_addr_r];
			endcase
		end
	end

	// launches on falling edges; the address counter outlives frames harmlessly
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pins_r    <= '0;
			out_sr_r  <= 8'h00;
			out_cnt_r <= 3'h0;
			rd_addr_r <= '0;
		end
		else if (cs_s)
		begin
			pins_r    <= '0;
			out_cnt_r <= 3'h0;
		end
		else if (addr_load)
		begin
			rd_addr_r <= in_sr_nxt[ADDR_W-1:0];
		end
		else if (state_r == sfsrc_pkg::ST_MONITOR)
		begin
			// follows the flag every cycle, no clock edges needed
			pins_r.io1_o  <= busy_now;
			pins_r.io1_oe <= 1'b1;
		end
		else if (state_r == sfsrc_pkg::ST_DATA && sck_fall)
		begin
			pins_r.io1_o  <= cur_byte[7];
			pins_r.io1_oe <= 1'b1;
			pins_r.io0_o  <= cur_byte[6];
			pins_r.io0_oe <= dual_out_r;
			if (dual_out_r)
			begin
				out_sr_r  <= {cur_byte[5:0], 2'b00};
				out_cnt_r <= out_cnt_r + 3'h2;
			end
			else
			begin
				out_sr_r  <= {cur_byte[6:0], 1'b0};
				out_cnt_r <= out_cnt_r + 3'h1;
			end
			// natural overflow of the counter wraps to address zero
			if (out_cnt_r == 3'h0 && src_r == sfsrc_pkg::SRC_ARRAY)
			begin
				rd_addr_r <= rd_addr_r + 1'b1;
			end
		end
	end

	assign io_out = pins_r;

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	assign busy_now     = (wip_cnt_r != '0) | array_busy;
	assign wip_done     = (wip_cnt_r == WIP_W'(1));
	assign stat_word    = {stat_r[15:1], busy_now};
	// upper lock set means power lock-down or one-time lock: never writable
	assign write_locked = stat_r[sfsrc_pkg::BIT_LOCK_UPPER]
		| (stat_r[sfsrc_pkg::BIT_LOCK_LOWER] & ~wp_s);

	// only a select rise after exactly 8 or 16 bits with the latch set counts
	assign status_write_command_go = cs_rise && state_r == sfsrc_pkg::ST_STATUS_IN
		&& (cnt_r == sfsrc_pkg::WRITE_SHORT_BITS
		|| cnt_r == sfsrc_pkg::WRITE_LONG_BITS)
		&& stat_r[sfsrc_pkg::BIT_WEL]
		&& !busy_now && !write_locked;

	// merge of new data; first byte sent is the low byte
	always_comb
	begin
		if (cnt_r == sfsrc_pkg::WRITE_LONG_BITS)
		begin
			stat_written = (stat_r & ~sfsrc_pkg::MASK_WORD_WRITE)
				| ({in_sr_r[7:0], in_sr_r[15:8]} & sfsrc_pkg::MASK_WORD_WRITE);
		end
		else
		begin
			stat_written = (stat_r & ~sfsrc_pkg::MASK_BYTE_WRITE)
				| ({8'h00, in_sr_r[7:0]} & sfsrc_pkg::MASK_BYTE_WRITE);
		end
		// one-time lock bits can be set but never cleared
		stat_written[sfsrc_pkg::LOCK_BITS_MSB:sfsrc_pkg::LOCK_BITS_LSB] =
			stat_written[sfsrc_pkg::LOCK_BITS_MSB:sfsrc_pkg::LOCK_BITS_LSB]
			| stat_r[sfsrc_pkg::LOCK_BITS_MSB:sfsrc_pkg::LOCK_BITS_LSB];
	end

	// stored bits; later statements win, so a new enable beats a completion
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stat_r <= sfsrc_pkg::STATUS_RESET;
		end
		else
		begin
			if (status_write_command_go)
			begin
				stat_r <= stat_written;
			end
			if (wip_done)
			begin
				stat_r[sfsrc_pkg::BIT_WEL] <= 1'b0;
			end
			if (opc_done)
			begin
				case (in_sr_nxt[7:0])
					sfsrc_pkg::OPC_WRITE_ENABLE:
					begin
						stat_r[sfsrc_pkg::BIT_WEL] <= 1'b1;
					end
					sfsrc_pkg::OPC_WRITE_DISABLE:
					begin
						stat_r[sfsrc_pkg::BIT_WEL] <= 1'b0;
					end
					sfsrc_pkg::OPC_ERASE_SUSPEND:
					begin
						stat_r[sfsrc_pkg::BIT_ERASE_SUSPENDED] <= 1'b1;
					end
					sfsrc_pkg::OPC_PROGRAM_SUSPEND:
					begin
						stat_r[sfsrc_pkg::BIT_PROG_SUSPENDED] <= 1'b1;
					end
					sfsrc_pkg::OPC_RESUME_A, sfsrc_pkg::OPC_RESUME_B:
					begin
						stat_r[sfsrc_pkg::BIT_ERASE_SUSPENDED] <= 1'b0;
						stat_r[sfsrc_pkg::BIT_PROG_SUSPENDED]  <= 1'b0;
					end
					default:
					begin
						stat_r[sfsrc_pkg::BIT_WEL] <= stat_r[sfsrc_pkg::BIT_WEL];
					end
				endcase
			end
		end
	end

	// self-timed write cycle; busy for exactly the cycle count
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wip_cnt_r <= '0;
		end
		else if (status_write_command_go)
		begin
			wip_cnt_r <= WIP_W'(STATUS_WRITE_COMMAND_CYCLE_CLKS);
		end
		else if (wip_cnt_r != '0)
		begin
			wip_cnt_r <= wip_cnt_r - 1'b1;
		end
	end

	// registered status view for the surrounding chip
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_word_r <= sfsrc_pkg::STATUS_RESET;
		end
		else
		begin
			status_word_r <= stat_word;
		end
	end

	assign status_word = status_word_r;

endmodule

`default_nettype wire

// ===== dv/sfsrc_flash_front_asserts.sv
// assertion checker for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module sfsrc_flash_front_asserts #(
	parameter int unsigned STATUS_WRITE_COMMAND_CYCLE_CLKS = 20
) (
	input wire logic			clk,
	input wire logic			sys_rst,
	input wire logic			cs_n,
	input wire logic			array_busy,
	input wire sfsrc_pkg::sfsrc_io_t	io_out,
	input wire logic [15:0]		status_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [15:0] busy_run_r; // clocks of self-timed busy
	// ------------------------------------------------
	// busy length counter, array busy time excluded
	// ------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst || !status_word[0] || array_busy)
			busy_run_r <= 16'h0000;
		else
			busy_run_r <= busy_run_r + 16'h0001;
	end
	sequence wr_start_s;
		$rose(status_word[0]) && !array_busy;
	endsequence
	sequence wr_hold_s;
		status_word[0] [*8];
	endsequence
	idle_release_a: assert property (cs_n [*6] |-> io_out == 4'h0)
		else $error("output driven while deselected");
	busy_hold_a: assert property (wr_start_s |-> wr_hold_s)
		else $error("write busy dropped early");
	busy_bound_a: assert property (busy_run_r <= STATUS_WRITE_COMMAND_CYCLE_CLKS + 2)
		else $error("write busy too long");
	latch_clear_a: assert property ($fell(status_word[0]) && !$past(array_busy)
		&& !$past(array_busy, 2) |-> !status_word[1])
		else $error("latch kept after write");
	oe_framed_a: assert property ($rose(io_out.io1_oe) |-> !$past(cs_n, 4))
		else $error("drive began outside frame");
	dual_pair_a: assert property (io_out.io0_oe |-> io_out.io1_oe)
		else $error("lower line driven alone");
	susp_framed_a: assert property ($changed({status_word[15], status_word[10]})
		|-> !$past(cs_n, 4))
		else $error("suspend flag moved outside frame");
	cfg_after_cs_a: assert property ($changed(status_word[9:2]) |-> $past(cs_n, 2))
		else $error("status changed inside frame");
endmodule
bind sfsrc_flash_front sfsrc_flash_front_asserts #(.STATUS_WRITE_COMMAND_CYCLE_CLKS(STATUS_WRITE_COMMAND_CYCLE_CLKS))
	sfsrc_flash_front_asserts_inst (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
	.array_busy(array_busy), .io_out(io_out), .status_word(status_word));
`default_nettype wire

// ===== dv/sfsrc_host_model.sv
// behavioural host link controller, mode 0
`timescale 1ns/1ps
`default_nettype none
module sfsrc_host_model (
	output logic			sclk,
	output logic			cs_n,
	output logic			io0_h,
	output logic			io1_h,
	input wire sfsrc_pkg::sfsrc_io_t	io_out
);
	logic [7:0] rx_s; // byte seen on one line
	logic [7:0] rx_d; // byte seen on two lines
	// deselected, clock parked low
	initial
	begin
		{sclk, cs_n, io0_h, io1_h} = 4'b0100;
	end
	// one clock: set lines while low, capture, rise, fall
	task automatic tick(input logic d1, input logic d0, input logic [1:0] m);
		io1_h = m[1] ? d1 : ~io1_h; // released line toggles
		io0_h = m[0] ? d0 : ~io0_h;
		#62.5;
		// an undriven line reads inverted, so a missing enable cannot pass
		rx_s = {rx_s[6:0], io_out.io1_oe ? io_out.io1_o : ~io_out.io1_o};
		rx_d = {rx_d[5:0], io_out.io1_oe ? io_out.io1_o : ~io_out.io1_o,
			io_out.io0_oe ? io_out.io0_o : ~io_out.io0_o};
		sclk = 1'b1;
		#62.5;
		sclk = 1'b0;
	endtask
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			tick(1'b0, b[i], 2'b01);
	endtask
	task automatic send2(input logic [7:0] b);
		for (int i = 3; i >= 0; i--)
			tick(b[2*i+1], b[2*i], 2'b11);
	endtask
	task automatic idle(input int n);
		repeat (n) tick(1'b0, 1'b0, 2'b00);
	endtask
	task automatic cs_lo();
		cs_n = 1'b0;
		#62.5;
	endtask
	// clock held low while selected and between frames
	task automatic cs_hi();
		#62.5;
		cs_n = 1'b1;
		#62.5;
	endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic			clk = 1'b0;
	logic			sys_rst, wp_n, array_busy, mem_load_en, oe_seen;
	wire logic		sclk, cs_n, io0_h, io1_h;
	logic [7:0]		mem_load_addr, mem_load_data, r;
	logic [7:0]		mem [256];	// array mirror
	logic [15:0]		sw;		// expected status
	wire logic [15:0]	status_word;
	sfsrc_pkg::sfsrc_io_t	io_out;
	int			error_cnt, tests_run, seed;
	logic [7:0]		sus_ops [6] = '{8'h75, 8'hb0, 8'h7a, 8'hb0, 8'h30, 8'h75};
	always #2.5 clk = ~clk;
	always @(posedge clk) if (io_out.io1_oe) oe_seen = 1'b1;
	sfsrc_flash_front #(.ADDR_W(8), .STATUS_WRITE_COMMAND_CYCLE_CLKS(20)) sfsrc_flash_front_inst (
		.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
		.io0_i(io_out.io0_oe ? io_out.io0_o : io0_h),
		.io1_i(io_out.io1_oe ? io_out.io1_o : io1_h), .wp_n(wp_n),
		.array_busy(array_busy), .mem_load_en(mem_load_en),
		.mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
		.io_out(io_out), .status_word(status_word));
	sfsrc_host_model host (.sclk(sclk), .cs_n(cs_n), .io0_h(io0_h), .io1_h(io1_h),
		.io_out(io_out));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (e !== s)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic frame(input logic [7:0] op);
		host.cs_lo();
		host.send(op);
		host.cs_hi();
	endtask
	// read n bytes from a, dual ops take the data two bits a clock
	task automatic rd(input logic [7:0] op, input logic [7:0] a, input int n);
		logic dual;
		dual = (op == sfsrc_pkg::OPC_DUAL_OUTPUT_READ || op == 8'hbb);
		host.cs_lo();
		host.send(op);
		if (op == 8'hbb)
			for (int i = 0; i < 3; i++) host.send2(i == 2 ? a : 8'($random(seed)));
		else
			for (int i = 0; i < 3; i++) host.send(i == 2 ? a : 8'($random(seed)));
		if (op != 8'h03) host.idle(8);
		for (int k = 0; k < n; k++)
		begin
			host.idle(dual ? 4 : 8);
			chk("read", {8'h00, mem[8'(a + k)]}, {8'h00, dual ? host.rx_d : host.rx_s});
		end
		host.cs_hi();
	endtask
	// status write of n bits, ok says if it must execute
	task automatic wr(input logic [15:0] d, input int n, input logic ok);
		logic [15:0] m;
		m = (n == 16) ? sfsrc_pkg::MASK_WORD_WRITE : sfsrc_pkg::MASK_BYTE_WRITE;
		host.cs_lo();
		host.send(sfsrc_pkg::OPC_STATUS_WRITE);
		for (int k = 0; k < n; k++) host.tick(1'b0, k < 8 ? d[7-k] : d[23-k], 2'b01);
		host.cs_hi();
		if (ok)
		begin
			sw = (sw & ~m) | (d & m) | (sw & 16'h3800);
			chk("busy", 16'h0001, {15'h0000, status_word[0]});
			for (int t = 0; t < 60 && status_word[0] !== 1'b0; t++) @(posedge clk);
			#1 chk("done", 16'h0000, {14'h0000, status_word[1:0]});
		end
		chk("status", {sw[15:2], 2'b00}, {status_word[15:2], 2'b00});
	endtask
	initial
	begin
		#400000 error_cnt++;
		give_verdict();
	end
	initial
	begin
		{seed, error_cnt, tests_run, sw, mem_load_addr, mem_load_data} = {32'd93, 64'd0, 32'd0};
		{sys_rst, wp_n, array_busy, mem_load_en, oe_seen} = 5'b11000;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 256; i++)
		begin
			mem[i] = 8'($random(seed));
			{mem_load_en, mem_load_addr, mem_load_data} = {1'b1, 8'(i), mem[i]};
			@(posedge clk);
			#1;
		end
		mem_load_en = 1'b0;
		chk("reset", 16'h0000, status_word);
		rd(8'h03, 8'hfe, 3);
		rd(8'h0b, 8'($random(seed)), 2);
		rd(8'h3b, 8'($random(seed)), 2);
		rd(8'hbb, 8'hff, 2);
		rd(8'h03, 8'h10, 0);
		chk("release", 16'h0000, {12'h000, io_out});
		@(posedge clk) #1 array_busy = 1'b1;
		foreach (sus_ops[i])
		begin
			oe_seen = 1'b0;
			if (i < 3) rd(i == 0 ? 8'h0b : i == 1 ? 8'h3b : 8'hbb, 8'h00, 0);
			if (i < 3) chk("refused", 16'h0000, {15'h0000, oe_seen});
		end
		host.cs_lo();
		host.send(sfsrc_pkg::OPC_BUSY_MONITOR);
		host.tick(1'b0, 1'($random(seed)), 2'b01);
		repeat (10) @(posedge clk);
		#1 chk("monitor", 16'h0003, {14'h0000, io_out.io1_oe, io_out.io1_o});
		@(posedge clk) #1 array_busy = 1'b0;
		repeat (6) @(posedge clk);
		#1 chk("monitor", 16'h0002, {14'h0000, io_out.io1_oe, io_out.io1_o});
		host.cs_hi();
		chk("release", 16'h0000, {12'h000, io_out});
		foreach (sus_ops[i])
		begin
			frame(sus_ops[i]);
			if (sus_ops[i] == 8'h75) sw[15] = 1'b1;
			if (sus_ops[i] == 8'hb0) sw[10] = 1'b1;
			if (sus_ops[i] == 8'h7a || sus_ops[i] == 8'h30) {sw[15], sw[10]} = 2'b00;
			chk("suspend", sw, status_word);
		end
		r = 8'($random(seed));
		wr(16'h00fc, 8, 1'b0);
		frame(sfsrc_pkg::OPC_WRITE_ENABLE);
		wr({r, r}, 9, 1'b0);
		wr({r & 8'h42 | 8'h84, r & 8'h7f}, 16, 1'b1);
		frame(sfsrc_pkg::OPC_WRITE_ENABLE);
		wr({~r, r | 8'h83}, 8, 1'b1);
		frame(sfsrc_pkg::OPC_WRITE_ENABLE);
		chk("latch", 16'h0001, {15'h0000, status_word[1]});
		frame(sfsrc_pkg::OPC_WRITE_DISABLE);
		chk("latch", 16'h0000, {15'h0000, status_word[1]});
		host.cs_lo();
		host.send(sfsrc_pkg::OPC_READ_STATUS_HIGH);
		host.idle(8);
		chk("status high", {8'h00, sw[15:8]}, {8'h00, host.rx_s});
		host.cs_hi();
		@(posedge clk) #1 wp_n = 1'b0;
		frame(sfsrc_pkg::OPC_WRITE_ENABLE);
		wr(16'h00fc ^ {r, r}, 16, 1'b0);
		give_verdict();
	end
endmodule
`default_nettype wire
